// file: async_serial_baud_and_line_control_tb.sv
// Self-checking testbench for the serial line controller
`timescale 1ns/100ps

module async_serial_baud_and_line_control_tb;
	import uart_line_pkg::*;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, wait_mode, rx_line, tx_wire;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, tx_pin_out, tx_pin_oe, rx_pin_used, irq_request;
	logic        err, ok, par_on, par_odd, stuck;
	logic [8:0]  d, got;
	logic [2:0]  cfg;
	int          n_fail, comparisons, seed, dv, n;

	// Pull-up on the shared transmit wire when nobody drives it
	assign tx_wire = tx_pin_oe ? tx_pin_out : 1'h1;

	uart_line_ctrl u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wait_mode(wait_mode),
		.rx_pin(rx_line), .tx_pin_in(tx_wire), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_used(rx_pin_used),
		.irq_request(irq_request));
	serial_remote_node u_node (.pclk(pclk), .line_in(tx_wire), .line_out(rx_line));

	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic complete_run;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'h1 && t < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (t >= 50) begin
			n_fail++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'h1, a, v, rd, err);
	endtask

	task automatic wait_rx;
		int t;
		t = 0;
		rd = '0;
		while (rd[ST_BRK-4] !== 1'h1 && t < 3000) begin
			apb(1'h0, OFS_STATUS, 32'h0, rd, err);
			t++;
		end
		if (t >= 3000) begin
			n_fail++;
			complete_run();
		end
	endtask

	task automatic restore(input int k);
		case (k)
			0: wr(OFS_BD_LOW, dv);
			1: wait_mode <= 1'h0;
			3: clk_en <= 1'h1;
			default: wr(OFS_GATE, 32'h1);
		endcase
	endtask

	function automatic logic [8:0] exp_char(input logic [8:0] v, input int nb, input logic p, input logic o);
		logic [8:0] m;
		m = (nb == 9) ? 9'h1ff : 9'h0ff;
		v = v & m;
		if (p)
			v[nb-1] = ^(v & (m >> 1)) ^ o;
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] ofs [4];
		logic [7:0] rst [4];
		ofs = '{OFS_BD_HIGH, OFS_BD_LOW, OFS_CTRL_ONE, OFS_GATE};
		rst = '{RST_BD_HIGH, RST_BD_LOW, RST_CTRL_ONE, {7'h0, RST_GATE}};
		seed = 49;
		n_fail = 0;
		comparisons = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata, wait_mode} = '0;
		clk_en = 1'h1;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		chk(tx_pin_out, 1, "idle line");
		for (int i = 0; i < 4; i++) begin
			apb(1'h0, ofs[i], 32'h0, rd, err);
			chk(rd, rst[i], "reset value");
		end
		apb(1'h0, 8'h1c, 32'h0, rd, err);
		chk({rd[31:1], err}, 1, "unmapped read");
		wr(OFS_BD_HIGH, 32'hff);
		apb(1'h0, OFS_BD_HIGH, 32'h0, rd, err);
		chk(rd, BD_HIGH_MASK, "high divisor readback");
		for (int i = 0; i < 8; i++) begin
			dv = 1 + ($unsigned($random(seed)) % 3);
			cfg = i[2:0];
			n = cfg[2] ? 9 : 8;
			par_on = cfg[1];
			par_odd = cfg[0];
			wr(OFS_BD_HIGH, 32'h0);
			wr(OFS_BD_LOW, dv);
			wr(OFS_BD_HIGH, 32'h41);
			wr(OFS_CTRL_ONE, {27'h0, cfg[2], 2'h0, cfg[1:0]});
			wr(OFS_CTRL_TWO, 32'h0c);
			d = $random(seed);
			fork
				u_node.recv(n, 16 * dv, got, ok);
				wr(OFS_DATA, d);
			join
			chk(ok, 1, "tx framing");
			chk(got, exp_char(d, n, par_on, par_odd), "tx char");
			d = exp_char($random(seed), n, par_on, par_odd);
			u_node.send(d, n, 16 * dv);
			wait_rx();
			chk(rd[3:0], 0, "rx error flags");
			chk(irq_request, 1, "edge request");
			apb(1'h0, OFS_DATA, 32'h0, rd, err);
			chk(rd[8:0] & exp_char(9'h1ff, n, 1'h0, 1'h0), d, "rx char");
			wr(OFS_BD_HIGH, 32'h0);
			@(posedge pclk);
			chk(irq_request, 0, "edge request masked");
			wr(OFS_STATUS, 32'h31f);
		end
		wr(OFS_CTRL_ONE, 32'h0);
		for (int k = 0; k < 4; k++) begin
			if (k == 0)
				wr(OFS_BD_LOW, 32'h0);
			else if (k == 1) begin
				wr(OFS_CTRL_ONE, 32'h40);
				wait_mode <= 1'h1;
			end else if (k == 2)
				wr(OFS_GATE, 32'h0);
			d = $random(seed);
			wr(OFS_DATA, d);
			// Clock enable freeze: the write has landed, nothing may move after it
			if (k == 3)
				clk_en <= 1'h0;
			stuck = 1'h0;
			repeat (100) begin
				@(posedge pclk);
				stuck = stuck | (tx_pin_out !== 1'h1);
			end
			chk(stuck, 0, "frozen transmitter");
			fork
				u_node.recv(8, 16 * dv, got, ok);
				restore(k);
			join
			chk({ok, got}, {1'h1, exp_char(d, 8, 1'h0, 1'h0)}, "resumed char");
		end
		wr(OFS_CTRL_ONE, 32'h80);
		@(posedge pclk);
		chk(rx_pin_used, 0, "rx pin in loopback");
		d = $random(seed);
		wr(OFS_DATA, d);
		wait_rx();
		apb(1'h0, OFS_DATA, 32'h0, rd, err);
		chk(rd[7:0], d[7:0], "loopback char");
		wr(OFS_CTRL_ONE, 32'h0);
		@(posedge pclk);
		chk(rx_pin_used, 1, "rx pin normal");
		wr(OFS_CTRL_ONE, 32'ha0);
		wr(OFS_CTRL_TWO, 32'h1c);
		@(posedge pclk);
		chk(tx_pin_oe, 1, "single wire drive");
		wr(OFS_CTRL_TWO, 32'h0c);
		@(posedge pclk);
		chk(tx_pin_oe, 0, "single wire listen");
		wr(OFS_CTRL_TWO, 32'h8c);
		@(posedge pclk);
		chk(tx_pin_out, 0, "inverted idle line");
		wr(OFS_CTRL_ONE, 32'h0);
		wr(OFS_CTRL_TWO, 32'h2c);
		wr(OFS_BD_HIGH, 32'h80);
		wr(OFS_STATUS, 32'h31f);
		u_node.send_low(16 * dv * 12);
		apb(1'h0, OFS_STATUS, 32'h0, rd, err);
		chk(rd[ST_BRK], 1, "break flag");
		chk(irq_request, 1, "break request");
		wr(OFS_BD_HIGH, 32'h0);
		@(posedge pclk);
		chk(irq_request, 0, "break request masked");
		complete_run();
	end
endmodule

// file: serial_remote_node.sv
// Remote serial node model on the far side of the transmit and receive lines
`timescale 1ns/100ps

module serial_remote_node (
	input  wire logic pclk,
	input  wire logic line_in,
	output logic      line_out
);
	initial line_out = 1'h1;

	// ----------------------------------------------------------------
	// Frame sender: called just after a rising edge
	// ----------------------------------------------------------------
	task automatic send(input logic [8:0] v, input int nb, input int bitc);
		line_out <= 1'h0;
		repeat (bitc) @(posedge pclk);
		for (int i = 0; i < nb; i++) begin
			line_out <= v[i];
			repeat (bitc) @(posedge pclk);
		end
		line_out <= 1'h1;
		repeat (bitc) @(posedge pclk);
	endtask

	task automatic send_low(input int cyc);
		line_out <= 1'h0;
		repeat (cyc) @(posedge pclk);
		line_out <= 1'h1;
		repeat (32) @(posedge pclk);
	endtask

	// ----------------------------------------------------------------
	// Frame receiver: samples mid-bit, so a wrong bit time corrupts data
	// ----------------------------------------------------------------
	task automatic recv(input int nb, input int bitc, output logic [8:0] v, output logic ok);
		int t;
		t = 0;
		v = '0;
		ok = 1'h0;
		while (line_in !== 1'h0 && t < 20000) begin
			@(posedge pclk);
			t++;
		end
		if (t < 20000) begin
			repeat (bitc / 2) @(posedge pclk);
			ok = (line_in === 1'h0);
			for (int i = 0; i < nb; i++) begin
				repeat (bitc) @(posedge pclk);
				v[i] = line_in;
			end
			repeat (bitc) @(posedge pclk);
			ok = ok & (line_in === 1'h1);
		end
	endtask
endmodule

// file: uart_line_ctrl.sv
// Serial line controller: APB registers, baud divider, transmitter and receiver
//
// Functional notes
// - Clock gate bit set by reset; clearing it stops the serial logic.
// - High divisor byte is buffered; working divisor updates on low-byte write.
// - Divisor 1..8191 gives one bit per sixteen divider ticks.
// - Divisor zero stops the baud generator completely.
// - Low byte resets non-zero; generator idle until tx or rx enable written.
// - Break flag requests interrupt when its enable bit 7 is set.
// - Receive edge flag requests interrupt when its enable bit 6 is set.
// - Loopback routes transmitter output to receiver, receive pin unused.
// - Source bit under loopback picks internal loop or single-wire pin.
// - Wait freeze bit stops serial clocks while processor waits.
// - Eight or nine data bits, lsb first, between start and stop.
// - Wake bit picks idle-line or address-mark wakeup from standby.
// - Idle needs 10 or 11 high bit times, counted from start or stop.
// - Parity generated and checked in the most significant data bit.
// - Parity type selects even or odd count of ones.
// - Overrun, parity, framing and noise errors are flagged.
// - Optional 13-bit break send and break detection.
// - Double-buffered transmitter and receiver with separate enables.
// - Transmit output polarity can be inverted.
// - Direction bit decides drive of shared pin in single-wire mode.
// - Receive pin released whenever loopback is selected.
`timescale 1ns/100ps

module uart_line_ctrl
	import uart_line_pkg::*;
#(
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic              wait_mode,
	input  wire logic              rx_pin,
	input  wire logic              tx_pin_in,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   tx_pin_out,
	output logic                   tx_pin_oe,
	output logic                   rx_pin_used,
	output logic                   irq_request
);

	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 8 and 32");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  bdh;
		logic [4:0]  div_hi;
		logic [7:0]  bdl;
		logic [7:0]  c1;
		logic [7:0]  c2;
		logic        gate;
		logic        baud_run;
		logic [12:0] bcnt;
		tx_state_t   tx_st;
		logic [8:0]  tx_buf;
		logic        tx_full;
		logic [13:0] tx_sh;
		logic [3:0]  tx_left;
		logic [3:0]  tx_sub;
		logic        tx_line;
		logic        tc;
		rx_state_t   rx_st;
		logic [3:0]  rx_sub;
		logic [3:0]  rx_bit;
		logic [8:0]  rx_sh;
		logic [2:0]  rx_smp;
		logic        rx_noisy;
		logic [8:0]  rx_buf;
		logic        rdrf;
		logic        idle_f;
		logic        ovr_f;
		logic        noise_f;
		logic        frame_f;
		logic        par_f;
		logic        edge_f;
		logic        brk_f;
		logic        rx_prev;
		logic [3:0]  idle_cnt;
		logic [3:0]  idle_sub;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        tx_out;
		logic        tx_oe;
		logic        rx_used;
		logic        irq;
	} state_t;

	function automatic state_t rst_val();
		state_t v;
		v          = '0;
		v.bdh      = RST_BD_HIGH;
		v.bdl      = RST_BD_LOW;
		v.c1       = RST_CTRL_ONE;
		v.c2       = RST_CTRL_TWO;
		v.gate     = RST_GATE;
		v.tx_line  = 1'b1;
		v.tx_out   = 1'b1;
		v.rx_prev  = 1'b1;
		v.idle_cnt = RST_IDLE_CNT;
		return v;
	endfunction

	localparam state_t S_RST = rst_val();

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] data_bits(input logic nine);
		return nine ? 4'h9 : 4'h8;
	endfunction

	function automatic logic odd_ones(input logic [8:0] d, input logic nine);
		return nine ? ^d : ^d[7:0];
	endfunction

	function automatic logic maj(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	state_t      s_r;
	state_t      s_nxt;
	logic [12:0] div;
	logic [7:0]  ofs;
	logic        up_zero;
	logic        setup;
	logic        wr;
	logic        rd;
	logic        dwr;
	logic        run;
	logic        tick;
	logic        rx_in;
	logic        smp_v;
	logic        smp_nz;
	logic        nine;
	logic [8:0]  rx_data;
	logic        rx_msb;
	logic [8:0]  tx_word;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt   = s_r;
		div     = {s_r.div_hi, s_r.bdl};
		ofs     = paddr[7:0];
		up_zero = (paddr >> 8) == '0;
		setup   = psel & ~penable;
		wr      = psel & penable & s_r.pready & pwrite & up_zero;
		rd      = psel & penable & s_r.pready & ~pwrite & up_zero;
		dwr     = wr && ofs == OFS_DATA;
		run     = s_r.gate & ~(wait_mode & s_r.c1[C1_WFRZ]);
		tick    = 1'b0;
		nine    = s_r.c1[C1_NINE];
		smp_v   = maj(s_r.rx_smp);
		smp_nz  = s_r.rx_smp != 3'b000 && s_r.rx_smp != 3'b111;
		rx_data = nine ? s_r.rx_sh : {1'b0, s_r.rx_sh[8:1]};
		rx_msb  = nine ? rx_data[8] : rx_data[7];
		tx_word = pwdata[8:0];
		if (!nine) begin
			tx_word[8] = 1'b0;
		end
		if (s_r.c1[C1_PE]) begin
			// Parity replaces the top data bit
			if (nine) begin
				tx_word[8] = 1'b0;
				tx_word[8] = odd_ones(tx_word, 1'b0) ^ s_r.c1[C1_PODD];
			end else begin
				tx_word[7] = 1'b0;
				tx_word[7] = odd_ones(tx_word, 1'b0) ^ s_r.c1[C1_PODD];
			end
		end
		// Loopback takes the transmitter; single-wire takes the shared pin
		if (s_r.c1[C1_LOOP]) begin
			rx_in = s_r.c1[C1_RECEIVER_SOURCE_SELECT] ? tx_pin_in : s_r.tx_line;
		end else begin
			rx_in = rx_pin;
		end

		// ------------------------------------------------------------
		// Bus slave: data is latched in setup so prdata comes from a flop
		// ------------------------------------------------------------
		s_nxt.pready  = setup;
		s_nxt.pslverr = 1'b0;
		if (setup) begin
			s_nxt.pslverr = 1'b0;
			case (ofs)
				OFS_BD_HIGH:  s_nxt.prdata = {24'h000000, s_r.bdh};
				OFS_BD_LOW:   s_nxt.prdata = {24'h000000, s_r.bdl};
				OFS_CTRL_ONE: s_nxt.prdata = {24'h000000, s_r.c1};
				OFS_CTRL_TWO: s_nxt.prdata = {24'h000000, s_r.c2};
				OFS_STATUS:   s_nxt.prdata = {22'h000000, s_r.brk_f, s_r.edge_f, ~s_r.tx_full, s_r.tc,
					s_r.rdrf, s_r.idle_f, s_r.ovr_f, s_r.noise_f, s_r.frame_f, s_r.par_f};
				OFS_DATA:     s_nxt.prdata = {23'h000000, s_r.rx_buf};
				OFS_GATE:     s_nxt.prdata = {31'h00000000, s_r.gate};
				default: begin
					s_nxt.prdata  = 32'h00000000;
					s_nxt.pslverr = 1'b1;
				end
			endcase
			if (!up_zero) begin
				s_nxt.prdata  = 32'h00000000;
				s_nxt.pslverr = 1'b1;
			end
		end
		if (wr) begin
			case (ofs)
				OFS_BD_HIGH: s_nxt.bdh = pwdata[7:0] & BD_HIGH_MASK;
				OFS_BD_LOW: begin
					s_nxt.bdl    = pwdata[7:0];
					s_nxt.div_hi = s_r.bdh[4:0];
				end
				OFS_CTRL_ONE: s_nxt.c1 = pwdata[7:0];
				OFS_CTRL_TWO: begin
					s_nxt.c2 = pwdata[7:0];
					if (pwdata[C2_TXON] | pwdata[C2_RXON]) begin
						s_nxt.baud_run = 1'b1;
					end
				end
				OFS_STATUS: begin
					s_nxt.par_f   = s_r.par_f & ~pwdata[ST_PAR];
					s_nxt.frame_f = s_r.frame_f & ~pwdata[ST_FRAME];
					s_nxt.noise_f = s_r.noise_f & ~pwdata[ST_NOISE];
					s_nxt.ovr_f   = s_r.ovr_f & ~pwdata[ST_OVR];
					s_nxt.idle_f  = s_r.idle_f & ~pwdata[ST_IDLE];
					s_nxt.edge_f  = s_r.edge_f & ~pwdata[ST_EDGE];
					s_nxt.brk_f   = s_r.brk_f & ~pwdata[ST_BRK];
				end
				OFS_DATA: begin
					s_nxt.tx_buf  = tx_word;
					s_nxt.tx_full = 1'b1;
					s_nxt.tc      = 1'b0;
				end
				OFS_GATE: s_nxt.gate = pwdata[0];
				default: ;
			endcase
		end
		if (rd && ofs == OFS_DATA) begin
			s_nxt.rdrf = 1'b0;
		end

		// ------------------------------------------------------------
		// Serial side; hardware sets come after software clears
		// ------------------------------------------------------------
		if (run) begin
			if (s_r.baud_run && div != 13'h0000) begin
				if (s_r.bcnt >= div - 13'h0001) begin
					s_nxt.bcnt = 13'h0000;
					tick       = 1'b1;
				end else begin
					s_nxt.bcnt = s_r.bcnt + 13'h0001;
				end
			end
			s_nxt.rx_prev = rx_in;
			if (s_r.c2[C2_RXON] && s_r.rx_prev && !rx_in) begin
				s_nxt.edge_f = 1'b1;
			end
		end

		if (tick) begin
			// Transmitter
			unique case (s_r.tx_st)
				TX_IDLE: begin
					s_nxt.tx_line = 1'b1;
					if (s_r.c2[C2_TXON] && s_r.c2[C2_SBK]) begin
						s_nxt.tx_sh   = 14'h0000;
						s_nxt.tx_left = (s_r.c2[C2_BRK13] ? BRK_LONG : BRK_SHORT) + {3'b000, nine};
						s_nxt.tx_sub  = 4'h0;
						s_nxt.tx_line = 1'b0;
						s_nxt.tx_st   = TX_SEND;
					end else if (s_r.c2[C2_TXON] && s_r.tx_full) begin
						if (nine) begin
							s_nxt.tx_sh = {3'b000, 1'b1, s_r.tx_buf, 1'b0};
						end else begin
							s_nxt.tx_sh = {4'h0, 1'b1, s_r.tx_buf[7:0], 1'b0};
						end
						s_nxt.tx_left = data_bits(nine) + FRAME_XTRA;
						s_nxt.tx_sub  = 4'h0;
						s_nxt.tx_line = 1'b0;
						s_nxt.tx_full = dwr;
						s_nxt.tx_st   = TX_SEND;
					end else if (!s_r.tx_full && !dwr) begin
						s_nxt.tc = 1'b1;
					end
				end
				TX_SEND: begin
					s_nxt.tx_sub = s_r.tx_sub + 4'h1;
					if (s_r.tx_sub == SUB_LAST) begin
						s_nxt.tx_sh   = s_r.tx_sh >> 1;
						s_nxt.tx_left = s_r.tx_left - 4'h1;
						if (s_r.tx_left == 4'h1) begin
							s_nxt.tx_line = 1'b1;
							s_nxt.tx_st   = TX_IDLE;
						end else begin
							s_nxt.tx_line = s_r.tx_sh[1];
						end
					end
				end
			endcase

			// Idle detector runs ahead of the receiver so a stop-bit restart wins
			if (s_r.c2[C2_RXON]) begin
				if (!rx_in) begin
					s_nxt.idle_cnt = 4'h0;
					s_nxt.idle_sub = 4'h0;
				end else begin
					s_nxt.idle_sub = s_r.idle_sub + 4'h1;
					if (s_r.idle_sub == SUB_LAST && s_r.idle_cnt < IDLE_BITS + {3'b000, nine}) begin
						s_nxt.idle_cnt = s_r.idle_cnt + 4'h1;
						if (s_r.idle_cnt + 4'h1 == IDLE_BITS + {3'b000, nine}) begin
							s_nxt.idle_f = 1'b1;
							if (!s_r.c1[C1_WAKE]) begin
								s_nxt.c2[C2_RWU] = 1'b0;
							end
						end
					end
				end
			end

			// Receiver: three samples mid-bit, majority vote decides
			if (s_r.c2[C2_RXON]) begin
				unique case (s_r.rx_st)
					RX_IDLE: begin
						if (!rx_in) begin
							s_nxt.rx_st  = RX_START;
							s_nxt.rx_sub = 4'h0;
						end
					end
					RX_START, RX_DATA: begin
						s_nxt.rx_sub = s_r.rx_sub + 4'h1;
						if (s_r.rx_sub >= SMP_FIRST && s_r.rx_sub <= SMP_LAST) begin
							s_nxt.rx_smp = {s_r.rx_smp[1:0], rx_in};
						end
						if (s_r.rx_sub == SUB_LAST) begin
							if (s_r.rx_st == RX_START) begin
								s_nxt.rx_st    = smp_v ? RX_IDLE : RX_DATA;
								s_nxt.rx_bit   = 4'h0;
								s_nxt.rx_noisy = smp_nz;
							end else if (s_r.rx_bit < data_bits(nine)) begin
								s_nxt.rx_sh    = {smp_v, s_r.rx_sh[8:1]};
								s_nxt.rx_bit   = s_r.rx_bit + 4'h1;
								s_nxt.rx_noisy = s_r.rx_noisy | smp_nz;
							end else begin
								s_nxt.rx_st = RX_IDLE;
								if (s_r.c1[C1_ILT]) begin
									s_nxt.idle_cnt = 4'h0;
									s_nxt.idle_sub = 4'h0;
								end
								if (rx_data == 9'h000 && !smp_v && s_r.c2[C2_BRKDET]) begin
									s_nxt.brk_f = 1'b1;
								end
								if (!s_r.c2[C2_RWU] || (s_r.c1[C1_WAKE] && rx_msb)) begin
									s_nxt.c2[C2_RWU] = 1'b0;
									if (s_r.rdrf) begin
										s_nxt.ovr_f = 1'b1;
									end else begin
										s_nxt.rx_buf = rx_data;
										s_nxt.rdrf   = 1'b1;
										if (s_r.rx_noisy | smp_nz) begin
											s_nxt.noise_f = 1'b1;
										end
										if (!smp_v) begin
											s_nxt.frame_f = 1'b1;
										end
										if (s_r.c1[C1_PE] && odd_ones(rx_data, nine) != s_r.c1[C1_PODD]) begin
											s_nxt.par_f = 1'b1;
										end
									end
								end
							end
						end
					end
					default: s_nxt.rx_st = RX_IDLE;
				endcase
			end
		end

		// Registered pin and request outputs
		s_nxt.tx_out  = s_nxt.tx_line ^ s_nxt.c2[C2_TXINV];
		s_nxt.tx_oe   = (s_nxt.c2[C2_TXON] | (s_nxt.tx_st == TX_SEND))
			& ~(s_nxt.c1[C1_LOOP] & s_nxt.c1[C1_RECEIVER_SOURCE_SELECT] & ~s_nxt.c2[C2_DIR]);
		s_nxt.rx_used = s_nxt.c2[C2_RXON] & ~s_nxt.c1[C1_LOOP];
		s_nxt.irq     = (s_nxt.bdh[BDH_BRK_IE] & s_nxt.brk_f) | (s_nxt.bdh[BDH_EDGE_IE] & s_nxt.edge_f);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= S_RST;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign prdata      = s_r.prdata;
	assign pready      = s_r.pready;
	assign pslverr     = s_r.pslverr;
	assign tx_pin_out  = s_r.tx_out;
	assign tx_pin_oe   = s_r.tx_oe;
	assign rx_pin_used = s_r.rx_used;
	assign irq_request = s_r.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_brk_held;
		(clk_en && s_r.bdh[BDH_BRK_IE] && s_r.brk_f)[*2];
	endsequence

	property p_div_load;
		(wr && ofs == OFS_BD_LOW && clk_en) |=> div == {$past(s_r.bdh[4:0]), $past(pwdata[7:0])};
	endproperty
	a_div_load: assert property (p_div_load) else $error("divisor not loaded on low byte write");

	property p_div_hold;
		(wr && ofs == OFS_BD_HIGH && clk_en) |=> $stable(div);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("divisor changed on high byte write");

	property p_rate;
		(clk_en && run && s_r.baud_run && div != 13'h0000 && s_r.bcnt == div - 13'h0001) |-> tick ##1 s_r.bcnt == 13'h0000;
	endproperty
	a_rate: assert property (p_rate) else $error("baud tick missing at divisor end");

	property p_div_zero;
		(div == 13'h0000 && clk_en) |=> $stable(s_r.bcnt);
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("baud counter moves with zero divisor");

	property p_baud_idle;
		!s_r.baud_run |-> (s_r.bcnt == 13'h0000 && !tick);
	endproperty
	a_baud_idle: assert property (p_baud_idle) else $error("baud generator ran before enable");

	property p_irq_brk;
		s_brk_held |-> irq_request;
	endproperty
	a_irq_brk: assert property (p_irq_brk) else $error("break request missing");

	property p_irq_edge;
		(s_r.bdh[BDH_EDGE_IE] && s_r.edge_f) || (s_r.bdh[BDH_BRK_IE] && s_r.brk_f) || !irq_request;
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("request without enabled flag");

	property p_rx_pin;
		s_r.c1[C1_LOOP] |-> !rx_pin_used;
	endproperty
	a_rx_pin: assert property (p_rx_pin) else $error("receive pin held under loopback");

	property p_single_dir;
		(s_r.c1[C1_LOOP] && s_r.c1[C1_RECEIVER_SOURCE_SELECT] && !s_r.c2[C2_DIR]) |-> !tx_pin_oe;
	endproperty
	a_single_dir: assert property (p_single_dir) else $error("shared pin driven while set as input");

	property p_freeze;
		(clk_en && !run) |=> $stable(s_r.bcnt) && $stable(s_r.tx_sub) && $stable(s_r.rx_sub);
	endproperty
	a_freeze: assert property (p_freeze) else $error("serial logic ran while frozen");

	property p_tx_idle;
		s_r.tx_st == TX_IDLE |-> s_r.tx_line;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("line not high while idle");

endmodule

// file: uart_line_pkg.sv
// Shared constants and types for the serial line controller
package uart_line_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_BD_HIGH  = 8'h00;
	localparam logic [7:0] OFS_BD_LOW   = 8'h04;
	localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h0c;
	localparam logic [7:0] OFS_STATUS   = 8'h10;
	localparam logic [7:0] OFS_DATA     = 8'h14;
	localparam logic [7:0] OFS_GATE     = 8'h18;

	// ----------------------------------------------------------------
	// Values after reset and the high divisor write mask
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BD_HIGH  = 8'h00;
	localparam logic [7:0] RST_BD_LOW   = 8'h04;
	localparam logic [7:0] RST_CTRL_ONE = 8'h00;
	localparam logic [7:0] RST_CTRL_TWO = 8'h00;
	localparam logic       RST_GATE     = 1'b1;
	localparam logic [3:0] RST_IDLE_CNT = 4'hf;
	localparam logic [7:0] BD_HIGH_MASK = 8'hdf;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BDH_BRK_IE  = 7;
	localparam int BDH_EDGE_IE = 6;
	localparam int C1_LOOP     = 7;
	localparam int C1_WFRZ     = 6;
	localparam int C1_RECEIVER_SOURCE_SELECT     = 5;
	localparam int C1_NINE     = 4;
	localparam int C1_WAKE     = 3;
	localparam int C1_ILT      = 2;
	localparam int C1_PE       = 1;
	localparam int C1_PODD     = 0;
	localparam int C2_TXINV    = 7;
	localparam int C2_BRK13    = 6;
	localparam int C2_BRKDET   = 5;
	localparam int C2_DIR      = 4;
	localparam int C2_TXON     = 3;
	localparam int C2_RXON     = 2;
	localparam int C2_RWU      = 1;
	localparam int C2_SBK      = 0;
	localparam int ST_PAR      = 0;
	localparam int ST_FRAME    = 1;
	localparam int ST_NOISE    = 2;
	localparam int ST_OVR      = 3;
	localparam int ST_IDLE     = 4;
	localparam int ST_EDGE     = 8;
	localparam int ST_BRK      = 9;

	// ----------------------------------------------------------------
	// Cycle and bit counts
	// ----------------------------------------------------------------
	localparam logic [3:0] SUB_LAST   = 4'hf;
	localparam logic [3:0] SMP_FIRST  = 4'h7;
	localparam logic [3:0] SMP_LAST   = 4'h9;
	localparam logic [3:0] IDLE_BITS  = 4'ha;
	localparam logic [3:0] BRK_SHORT  = 4'ha;
	localparam logic [3:0] BRK_LONG   = 4'hd;
	localparam logic [3:0] FRAME_XTRA = 4'h2;

	typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11} rx_state_t;

endpackage
